/* fetxs_encoder.sv */
// 100 Mb/s transmit coder: 4B/5B, delimiters, scrambler, NRZI, plus a symbol decode monitor
//
// Summary of operation
// R1: Each 4-bit nibble becomes its fixed 5-bit data code-group from the sixteen-entry table.
// R2: 00100 is the halt (error) symbol and 11111 the idle symbol.
// R3: The first preamble byte of a frame is replaced by the start pair 11000 then 10001.
// R4: After the start pair every further nibble is encoded as data, or as halt when tx_er is set, while transmit enable holds.
// R5: When transmit enable drops the end pair 01101 then 00111 closes the frame.
// R6: After the end pair idles 11111 are sent continuously until transmit enable returns.
// R7: Decoding maps idle and end symbols to 0000 and both start symbols to 0101.
// R8: Idle, start or R symbols seen inside a data field decode as invalid with an error flag; T ends the field without one.
// R9: The scrambling sequence comes from a closed-loop 11-bit LFSR.
// R10: The LFSR output is XORed bit by bit with the serial NRZ code-group stream.
// R11: The scrambler seed is loaded from address straps [4:1], so PHYs differing only in strap bit 0 share a seed.
// R12: The scrambler can be bypassed so code-groups pass unscrambled.
// R13: The scrambled stream passes an NRZ-to-NRZI encoder before the line driver.
// R14: The nibble input becomes a 125 Mb/s serial symbol stream.
// R15: Transmission follows the idle, start, data, end sequence of the standard transmit machine.
// R16: Patterns outside the data and control tables (halt and the ten invalid codes) decode with an error flag.
// R17: Feedback polynomial is x^11 + x^9 + 1 and the seed is never all zeros.
`timescale 1ns/1ns
module fetxs_encoder (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// MAC nibble stream
	input wire logic i_tx_valid,
	input wire logic i_tx_en,
	input wire logic i_tx_er,
	input wire logic [fetxs_pkg::NIB_W-1:0] i_txd,
	output logic o_tx_ready,
	// Straps and configuration pins
	input wire logic [fetxs_pkg::STRAP_W-1:0] i_phy_address_straps,
	input wire logic i_scr_bypass,
	// Line side
	output logic o_line_nrzi,
	// Symbol decode monitor
	output logic o_dec_valid,
	output logic [fetxs_pkg::NIB_W-1:0] o_dec_nibble,
	output logic o_dec_err,
	output logic o_frame_active
);
	import fetxs_pkg::*;

	// ==========================================================
	// Code-group helpers
	function automatic logic [CG_W-1:0] enc(input logic [NIB_W-1:0] n);
		enc = CG_DATA[n]; // R1
	endfunction

	// Returns {error, control, nibble}
	function automatic logic [NIB_W+1:0] dec(input logic [CG_W-1:0] cg);
		logic [NIB_W+1:0] r;
		r = {2'b10, NIB_CTRL_IDLE}; // R16
		for (int i = 0; i < 16; i++)
			if (CG_DATA[i] == cg)
				r = {2'b00, NIB_W'(i)};
		if (cg == CG_IDLE || cg == CG_T || cg == CG_R)
			r = {2'b01, NIB_CTRL_IDLE}; // R7
		else if (cg == CG_J || cg == CG_K)
			r = {2'b01, NIB_CTRL_SSD}; // R7
		dec = r;
	endfunction

	// ==========================================================
	// Nibble FIFO
	logic f_valid;
	logic f_pop;
	logic [WORD_W-1:0] f_data;

	fetxs_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(i_tx_valid),
		.o_in_ready(o_tx_ready),
		.i_in_data({i_tx_er, i_tx_en, i_txd}),
		.o_out_valid(f_valid),
		.i_out_ready(f_pop),
		.o_out_data(f_data)
	);

	// ==========================================================
	// Pin synchronisers
	logic [STRAP_W-1:0] strap_s1_q, strap_s2_q;
	logic byp_s1_q, byp_s2_q;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			strap_s1_q <= '0;
			strap_s2_q <= '0;
			byp_s1_q <= 1'b0;
			byp_s2_q <= 1'b0;
		end
		else
		begin
			strap_s1_q <= i_phy_address_straps;
			strap_s2_q <= strap_s1_q;
			byp_s1_q <= i_scr_bypass;
			byp_s2_q <= byp_s1_q;
		end
	end

	// ==========================================================
	// Transmit sequencer and serialiser
	fetxs_state_t st_q, st_d;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic [CG_W-1:0] shift_q, shift_d, cg_q, cg_d;
	logic cg_load_q, cg_load_d;
	logic run_q;
	logic ld;
	logic head_en;
	logic [CG_W-1:0] nxt;

	always_comb
	begin
		ld = run_q && bit_cnt_q == SYM_LAST;
		head_en = f_valid && f_data[W_EN];
		st_d = st_q;
		nxt = CG_IDLE;
		f_pop = 1'b0;
		case (st_q) // R15
			ST_IDLE:
			begin
				if (head_en)
				begin
					// First preamble nibble is consumed by the start symbol
					f_pop = ld; // R3
					nxt = CG_J; // R3
					st_d = ld ? ST_SSD_J : st_q;
				end
				else
				begin
					f_pop = ld && f_valid;
					nxt = CG_IDLE; // R6
				end
			end
			ST_SSD_J:
			begin
				f_pop = ld && head_en; // R3
				nxt = CG_K; // R3
				st_d = ld ? ST_SSD_K : st_q;
			end
			ST_SSD_K, ST_DATA:
			begin
				// An empty FIFO mid-frame is an underrun and closes the frame
				f_pop = ld && f_valid;
				if (head_en)
				begin
					nxt = f_data[W_ER] ? CG_HALT : enc(f_data[NIB_W-1:0]); // R2 R4
					st_d = ld ? ST_DATA : st_q;
				end
				else
				begin
					nxt = CG_T; // R5
					st_d = ld ? ST_ESD_T : st_q;
				end
			end
			ST_ESD_T:
			begin
				nxt = CG_R; // R5
				st_d = ld ? ST_ESD_R : st_q;
			end
			ST_ESD_R:
			begin
				nxt = CG_IDLE; // R6
				st_d = ld ? ST_IDLE : st_q;
			end
			default:
			begin
				st_d = ST_IDLE;
			end
		endcase
		cg_d = ld ? nxt : cg_q;
		cg_load_d = ld;
		bit_cnt_d = !run_q ? bit_cnt_q : (ld ? 3'h0 : 3'(bit_cnt_q + 3'h1)); // R14
		shift_d = !run_q ? shift_q : (ld ? nxt : {shift_q[CG_W-2:0], 1'b0}); // R14
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			st_q <= ST_IDLE;
			bit_cnt_q <= 3'h0;
			shift_q <= CG_IDLE;
			cg_q <= CG_IDLE;
			cg_load_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			cg_q <= cg_d;
			cg_load_q <= cg_load_d;
		end
	end

	// ==========================================================
	// Scrambler and NRZI
	logic [1:0] init_cnt_q, init_cnt_d;
	logic run_d;
	logic [LFSR_W-1:0] lfsr_q, lfsr_d;
	logic nrzi_q, nrzi_d;
	logic fb, scr_bit;

	always_comb
	begin
		fb = lfsr_q[LFSR_TAP_HI] ^ lfsr_q[LFSR_TAP_LO]; // R17
		scr_bit = byp_s2_q ? shift_q[CG_W-1] : shift_q[CG_W-1] ^ fb; // R10 R12
		init_cnt_d = init_cnt_q;
		run_d = run_q;
		lfsr_d = lfsr_q;
		nrzi_d = nrzi_q;
		if (!run_q)
		begin
			// Straps are read only once they have crossed the synchroniser
			init_cnt_d = 2'(init_cnt_q + 2'h1);
			if (init_cnt_q == INIT_LOAD_CNT)
			begin
				lfsr_d = {strap_s2_q[STRAP_W-1:1], SEED_FILL}; // R11 R17
				run_d = 1'b1;
			end
		end
		else
		begin
			lfsr_d = {lfsr_q[LFSR_W-2:0], fb}; // R9
			nrzi_d = nrzi_q ^ scr_bit; // R13
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			init_cnt_q <= 2'h0;
			run_q <= 1'b0;
			lfsr_q <= LFSR_RST;
			nrzi_q <= 1'b0;
		end
		else
		begin
			init_cnt_q <= init_cnt_d;
			run_q <= run_d;
			lfsr_q <= lfsr_d;
			nrzi_q <= nrzi_d;
		end
	end

	assign o_line_nrzi = nrzi_q;

	// ==========================================================
	// Symbol decode monitor on the unscrambled code-groups
	logic [NIB_W+1:0] dres;
	logic dv_q, dv_d, derr_q, derr_d, in_data_q, in_data_d, frame_q, frame_d;
	logic [NIB_W-1:0] dnib_q, dnib_d;

	always_comb
	begin
		dres = dec(cg_q);
		dv_d = cg_load_q;
		dnib_d = cg_load_q ? dres[NIB_W-1:0] : dnib_q;
		// T is the legal end of a data field, other control symbols are not
		derr_d = cg_load_q && (dres[NIB_W+1] || (dres[NIB_W] && in_data_q && cg_q != CG_T)); // R8 R16
		in_data_d = in_data_q;
		frame_d = frame_q;
		if (cg_load_q)
		begin
			if (cg_q == CG_K)
				in_data_d = 1'b1;
			else if (cg_q == CG_T || cg_q == CG_IDLE)
				in_data_d = 1'b0;
			if (cg_q == CG_J)
				frame_d = 1'b1;
			else if (cg_q == CG_R || cg_q == CG_IDLE)
				frame_d = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			dv_q <= 1'b0;
			dnib_q <= '0;
			derr_q <= 1'b0;
			in_data_q <= 1'b0;
			frame_q <= 1'b0;
		end
		else
		begin
			dv_q <= dv_d;
			dnib_q <= dnib_d;
			derr_q <= derr_d;
			in_data_q <= in_data_d;
			frame_q <= frame_d;
		end
	end

	assign o_dec_valid = dv_q;
	assign o_dec_nibble = dnib_q;
	assign o_dec_err = derr_q;
	assign o_frame_active = frame_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	property p_enc_data;
		ld && (st_q == ST_SSD_K || st_q == ST_DATA) && head_en && !f_data[W_ER]
			|=> cg_q == enc($past(f_data[NIB_W-1:0]));
	endproperty
	a_enc_data: assert property (p_enc_data) else $error("data nibble mis-encoded"); // R1 R4

	property p_halt;
		ld && st_q == ST_DATA && head_en && f_data[W_ER] |=> cg_q == 5'h04;
	endproperty
	a_halt: assert property (p_halt) else $error("error nibble not sent as halt"); // R2

	property p_ssd;
		cg_load_q && cg_q == CG_J |-> ##5 (cg_load_q && cg_q == 5'h11);
	endproperty
	a_ssd: assert property (p_ssd) else $error("start symbol J not followed by K"); // R3

	property p_esd;
		ld && st_q == ST_DATA && !head_en |=> (cg_q == 5'h0D) ##5 (cg_q == 5'h07) ##5 (cg_q == 5'h1F);
	endproperty
	a_esd: assert property (p_esd) else $error("end pair or trailing idle missing"); // R5 R6

	property p_idle;
		ld && st_q == ST_IDLE && !head_en |=> cg_q == 5'h1F;
	endproperty
	a_idle: assert property (p_idle) else $error("idle gap carries non-idle symbol"); // R6

	property p_dec_ctrl;
		cg_load_q && (cg_q == CG_J || cg_q == CG_K) |=> o_dec_valid && o_dec_nibble == 4'h5;
	endproperty
	a_dec_ctrl: assert property (p_dec_ctrl) else $error("start symbol decoded wrongly"); // R7

	property p_dec_err;
		// Halt plus eight of the ten invalid patterns; data codes with two ones are legal
		cg_load_q && ((cg_q inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0C})
			|| (in_data_q && (cg_q == CG_IDLE || cg_q == CG_J))) |=> o_dec_err;
	endproperty
	a_dec_err: assert property (p_dec_err) else $error("invalid symbol not flagged"); // R8 R16

	property p_seed;
		$rose(run_q) |-> lfsr_q[LFSR_W-1:7] == $past(strap_s2_q[STRAP_W-1:1]) && lfsr_q != '0;
	endproperty
	a_seed: assert property (p_seed) else $error("scrambler seed not taken from straps"); // R11 R17

	property p_scramble;
		run_q && !byp_s2_q |=> (o_line_nrzi != $past(o_line_nrzi))
			== ($past(shift_q[CG_W-1]) ^ $past(lfsr_q[10]) ^ $past(lfsr_q[8]));
	endproperty
	a_scramble: assert property (p_scramble) else $error("line bit not scrambled NRZI"); // R9 R10 R13

	property p_bypass;
		run_q && byp_s2_q |=> (o_line_nrzi != $past(o_line_nrzi)) == $past(shift_q[CG_W-1]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass does not pass plain code-group"); // R12

	property p_rate;
		cg_load_q |=> !cg_load_q [*4] ##1 cg_load_q;
	endproperty
	a_rate: assert property (p_rate) else $error("symbol period not five bits"); // R14

	property p_onehot;
		$onehot(st_q);
	endproperty
	a_onehot: assert property (p_onehot) else $error("sequencer state not one-hot"); // R15

	c_frame: cover property (cg_load_q && cg_q == CG_J ##10 cg_load_q);
	c_halt: cover property (cg_load_q && cg_q == CG_HALT);
	c_bypass: cover property (run_q && byp_s2_q && cg_load_q && cg_q == CG_R);
	c_full: cover property (!o_tx_ready && run_q);

endmodule // fetxs_encoder

/* fetxs_pkg.sv */
// Constants, code-groups and state encoding for the 100 Mb/s transmit coder
package fetxs_pkg;

	// ==========================================================
	// Widths
	localparam int NIB_W = 4;
	localparam int CG_W = 5;
	localparam int STRAP_W = 5;
	localparam int LFSR_W = 11;
	localparam int WORD_W = 6;
	localparam int FIFO_DEPTH = 8;

	// ==========================================================
	// FIFO word layout: {tx_er, tx_en, txd[3:0]}
	localparam int W_ER = 5;
	localparam int W_EN = 4;

	// ==========================================================
	// Timing: one line bit per core clock at 125 Mb/s
	localparam int CLK_PERIOD_NS = 8;
	localparam int BIT_PERIOD_NS = 8;
	localparam int BIT_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYM_BITS = 5;
	localparam logic [2:0] SYM_LAST = 3'(SYM_BITS * BIT_CYCLES - 1);
	localparam logic [1:0] INIT_LOAD_CNT = 2'h2;

	// ==========================================================
	// Code-groups
	localparam logic [CG_W-1:0] CG_HALT = 5'h04;
	localparam logic [CG_W-1:0] CG_IDLE = 5'h1F;
	localparam logic [CG_W-1:0] CG_J = 5'h18;
	localparam logic [CG_W-1:0] CG_K = 5'h11;
	localparam logic [CG_W-1:0] CG_T = 5'h0D;
	localparam logic [CG_W-1:0] CG_R = 5'h07;
	localparam logic [CG_W-1:0] CG_DATA [16] = '{
		5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	localparam logic [NIB_W-1:0] NIB_CTRL_IDLE = 4'h0;
	localparam logic [NIB_W-1:0] NIB_CTRL_SSD = 4'h5;

	// ==========================================================
	// Scrambler
	localparam int LFSR_TAP_HI = 10;
	localparam int LFSR_TAP_LO = 8;
	localparam logic [LFSR_W-1:0] LFSR_RST = 11'h7FF;
	localparam logic [6:0] SEED_FILL = 7'h7F;

	// ==========================================================
	// Transmit sequencer
	typedef enum logic [5:0]
	{
		ST_IDLE = 6'b000001,
		ST_SSD_J = 6'b000010,
		ST_SSD_K = 6'b000100,
		ST_DATA = 6'b001000,
		ST_ESD_T = 6'b010000,
		ST_ESD_R = 6'b100000
	} fetxs_state_t;

endpackage

/* fetxs_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module fetxs_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	// ==========================================================
	// Storage and pointers (DEPTH must be a power of two)
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ready_q, ready_d, valid_q, valid_d;
	logic push, pop;

	always_comb
	begin
		push = i_in_valid && ready_q;
		pop = i_out_ready && valid_q;
		mem_d = mem_q;
		if (push)
			mem_d[wr_q] = i_in_data;
		wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
		rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
		cnt_d = (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
		// Flags registered so that ready reaches the source from a flop
		ready_d = cnt_d != (AW+1)'(DEPTH);
		valid_d = cnt_d != '0;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
			valid_q <= valid_d;
		end
	end

	assign o_in_ready = ready_q;
	assign o_out_valid = valid_q;
	assign o_out_data = mem_q[rd_q];

endmodule // fetxs_fifo

/* fetxs_mac_model.sv */
// Nibble word source standing in for the MAC side of the coder
`timescale 1ns/1ns
module fetxs_mac_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Word stream
	output logic o_tx_valid,
	output logic o_tx_en,
	output logic o_tx_er,
	output logic [3:0] o_txd,
	input wire logic i_tx_ready
);
	// ==========================================================
	// Word queue, {er, en, nibble}
	logic [5:0] word_q[$];
	int gap = 0;
	int wait_n = 0;

	task automatic push(input logic [5:0] w);
		word_q.push_back(w);
	endtask

	initial
	begin
		o_tx_valid = 1'b0;
		{o_tx_er, o_tx_en, o_txd} = 6'h00;
	end

	// ==========================================================
	// Hold each word until taken; gap slows the source
	always @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			o_tx_valid <= 1'b0;
		else if (!o_tx_valid || i_tx_ready)
		begin
			if (o_tx_valid)
			begin
				word_q.delete(0);
				wait_n = gap;
			end
			if (wait_n > 0)
				wait_n--;
			if (wait_n == 0 && word_q.size() > 0)
			begin
				o_tx_valid <= 1'b1;
				{o_tx_er, o_tx_en, o_txd} <= word_q[0];
			end
			else
			begin
				// Released lines toggle so stale data never looks valid
				o_tx_valid <= 1'b0;
				{o_tx_er, o_tx_en, o_txd} <= ~{o_tx_er, o_tx_en, o_txd};
			end
		end
	end
endmodule // fetxs_mac_model

/* fetxs_encoder_bench.sv */
// Self-checking bench for the transmit coder
`timescale 1ns/1ns
module fetxs_encoder_bench;
	// ==========================================================
	// Pins and observation
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [4:0] straps = 5'h00;
	logic bypass = 1'b1;
	logic tx_valid, tx_en, tx_er, tx_ready, line, dec_valid, dec_err, frame_active;
	logic [3:0] txd, dec_nibble;
	logic prev_line = 1'b0;
	logic log_on = 1'b0;
	logic saw_full = 1'b0;
	logic saw_active = 1'b0;
	logic [4:0] dq[$];
	logic bq[$];
	int err_count = 0;
	int total_checks = 0;
	// Own table, kept apart from the design's copy
	logic [4:0] code_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	always #4 i_core_clk = ~i_core_clk;

	fetxs_encoder dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_tx_valid(tx_valid),
		.i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd), .o_tx_ready(tx_ready),
		.i_phy_address_straps(straps), .i_scr_bypass(bypass), .o_line_nrzi(line),
		.o_dec_valid(dec_valid), .o_dec_nibble(dec_nibble), .o_dec_err(dec_err),
		.o_frame_active(frame_active));
	fetxs_mac_model mac_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_tx_valid(tx_valid),
		.o_tx_en(tx_en), .o_tx_er(tx_er), .o_txd(txd), .i_tx_ready(tx_ready));

	// ==========================================================
	// Line recovery: NRZ bit is a change of the NRZI level
	always @(posedge i_core_clk)
	begin
		prev_line <= line;
		if (log_on)
		begin
			bq.push_back(line ^ prev_line);
			if (dec_valid)
				dq.push_back({dec_err, dec_nibble});
			if (!tx_ready)
				saw_full = 1'b1;
			if (frame_active)
				saw_active = 1'b1;
		end
	end

	// ==========================================================
	// Common tasks
	task check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task do_reset(input logic [4:0] s, input logic byp);
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		straps <= s;
		bypass <= byp;
		log_on <= 1'b0;
		repeat (10) @(posedge i_core_clk);
		check({tx_ready, line, dec_valid, frame_active}, 4'h0);
		i_rst_n <= 1'b1;
		dq.delete();
		bq.delete();
	endtask

	// ==========================================================
	// Full frame, unscrambled: codes, delimiters, halt, idles, fill
	task t_frame;
		int k;
		int j;
		int hit;
		logic m;
		logic [4:0] syms[$];
		logic eb[$];
		do_reset(5'h0A, 1'b1);
		log_on <= 1'b1;
		mac_u.push(6'h15);
		mac_u.push(6'h15);
		for (k = 0; k < 16; k++)
			mac_u.push({2'b01, 4'(k)});
		mac_u.push(6'h30);
		mac_u.push(6'h00);
		for (k = 0; k < 400 && dq.size() < 40; k++)
			@(posedge i_core_clk);
		check(saw_full, 1'b1);
		check(tx_ready, 1'b1);
		while (dq.size() > 0 && dq[0] === 5'h00)
			void'(dq.pop_front());
		check(dq[0], 5'h05);
		check(dq[1], 5'h05);
		for (k = 0; k < 16; k++)
			check(dq[2 + k], {1'b0, 4'(k)});
		check(dq[18][4], 1'b1);
		for (k = 19; k < 23; k++)
			check(dq[k], 5'h00);
		check({saw_active, frame_active}, 2'b10);
		syms = {5'h1F, 5'h18, 5'h11};
		for (k = 0; k < 16; k++)
			syms.push_back(code_tab[k]);
		syms = {syms, 5'h04, 5'h0D, 5'h07, 5'h1F, 5'h1F};
		foreach (syms[i])
			for (j = 4; j >= 0; j--)
				eb.push_back(syms[i][j]);
		hit = 0;
		for (k = 0; k + eb.size() <= bq.size(); k++)
		begin
			m = 1'b1;
			foreach (eb[i])
				if (bq[k + i] !== eb[i])
					m = 1'b0;
			if (m)
				hit = 1;
		end
		check(hit, 1);
	endtask

	// ==========================================================
	// Scrambled idles follow k[n] = k[n-11] ^ k[n-9]
	task t_scramble;
		int n;
		int bad;
		int zeros;
		do_reset(5'h0A, 1'b0);
		log_on <= 1'b1;
		repeat (120) @(posedge i_core_clk);
		log_on <= 1'b0;
		bad = 0;
		zeros = 0;
		for (n = 40; n < bq.size(); n++)
		begin
			if (~bq[n] !== (~bq[n - 11] ^ ~bq[n - 9]))
				bad++;
			if (bq[n] === 1'b0)
				zeros++;
		end
		check(bad, 0);
		check(zeros > 0, 1'b1);
	endtask

	// ==========================================================
	// Seed follows straps [4:1] only, never all zeros
	task rec_bits(input logic [4:0] s, output logic [39:0] v);
		do_reset(s, 1'b0);
		log_on <= 1'b1;
		repeat (70) @(posedge i_core_clk);
		log_on <= 1'b0;
		for (int i = 0; i < 40; i++)
			v[i] = bq[25 + i];
	endtask

	task t_seed;
		logic [39:0] a;
		logic [39:0] b;
		logic [39:0] c;
		logic [39:0] z;
		rec_bits(5'h1E, a);
		rec_bits(5'h1F, b);
		rec_bits(5'h1C, c);
		rec_bits(5'h01, z);
		check(a === b, 1'b1);
		check(a !== c, 1'b1);
		check(|(~z), 1'b1);
	endtask

	// ==========================================================
	// Sequence and watchdog
	initial
	begin
		t_frame;
		t_scramble;
		t_seed;
		stop_test;
	end

	initial
	begin
		#(8 * 5000);
		err_count++;
		stop_test;
	end
endmodule // fetxs_encoder_bench
